// ===== hw/dual_wiper_i2c_write_port.sv
// write-only two-wire target that sets two 256-tap wiper codes
// assumes scl/sda come from open-drain pins with external pull-ups;
// the pad combines sda_o/sda_oe_o with the bus wire
//
// Function
// - command 0x11 loads data into wiper a
// - command 0x12 loads data into wiper b
// - command 0x13 loads data into both wipers
// - wiper code is one msb-first data byte
// - each wiper offers 256 taps
// - never drive data; controller only writes
// - code equals taps counted from low end
// - fixed variant answers only address 0x5a
// - configurable address is 0101, pins, write bit
`timescale 1ns/1ps
module dual_wiper_i2c_write_port #(
    parameter bit FIXED_ADDR_VARIANT = 1'b0  // 1: fixed address variant
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe_o,
    input  wire logic                  addr_select_bit2_i,
    input  wire logic                  addr_select_bit1_i,
    input  wire logic                  addr_select_bit0_i,
    output wiper_pkg::wiper_pair_t     taps_from_low_end_o,
    output wiper_pkg::wiper_pair_t     taps_from_high_end_o,
    output logic                       wiper_updated_o
);

    // ---------------------------------------------------------------
    // command decode: bit 0 selects wiper a, bit 1 selects wiper b
    // ---------------------------------------------------------------
    function automatic logic [1:0] cmd_targets(input logic [7:0] cmd);
        logic [1:0] sel;
        sel = 2'h0;
        case (cmd)
            wiper_pkg::WIPER_A_WRITE_CMD:    sel = 2'h1;
            wiper_pkg::WIPER_B_WRITE_CMD:    sel = 2'h2;
            wiper_pkg::DUAL_WIPER_WRITE_CMD: sel = 2'h3;
            default:                         sel = 2'h0;
        endcase
        return sel;
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    logic [wiper_pkg::SYNC_W-1:0] pins_raw;   // scl, sda, address pins
    logic [wiper_pkg::SYNC_W-1:0] pins_init;  // idle bus seed
    logic [wiper_pkg::SYNC_W-1:0] pins_s;     // filtered levels
    logic                         scl_s;      // filtered clock
    logic                         sda_s;      // filtered data
    logic [2:0]                   addr_pins;  // filtered address straps

    assign pins_raw  = {scl_i, sda_i, addr_select_bit2_i,
                        addr_select_bit1_i, addr_select_bit0_i};
    assign pins_init = {2'h3, 3'h0};

    pin_sync3 #(
        .WIDTH (wiper_pkg::SYNC_W)
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .pin_i     (pins_raw),
        .init_i    (pins_init),
        .level_o   (pins_s)
    );

    assign scl_s     = pins_s[4];
    assign sda_s     = pins_s[3];
    assign addr_pins = pins_s[2:0];

    // ---------------------------------------------------------------
    // bus event detection
    // ---------------------------------------------------------------
    logic scl_prev_q;   // scl one cycle ago
    logic sda_prev_q;   // sda one cycle ago
    logic scl_prev_d;
    logic sda_prev_d;
    logic scl_rise;     // bit sampling point
    logic scl_fall;     // point to change our sda drive
    logic start_seen;   // sda falls while scl high
    logic stop_seen;    // sda rises while scl high

    // next values of the edge history
    always_comb begin
        scl_prev_d = scl_s;
        sda_prev_d = sda_s;
    end

    // edge history registers
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_prev_d;
            sda_prev_q <= sda_prev_d;
        end
    end

    assign scl_rise   = scl_s & ~scl_prev_q;
    assign scl_fall   = ~scl_s & scl_prev_q;
    assign start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_seen  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ---------------------------------------------------------------
    // expected address in 8-bit form, write bit included
    // ---------------------------------------------------------------
    logic [7:0] own_addr;

    always_comb begin
        if (FIXED_ADDR_VARIANT) begin
            own_addr = wiper_pkg::FIXED_TARGET_ADDR;
        end else begin
            own_addr = {wiper_pkg::ADDR_UPPER_BITS, addr_pins,
                        wiper_pkg::WRITE_BIT};
        end
    end

    // ---------------------------------------------------------------
    // receive state machine
    // ---------------------------------------------------------------
    wiper_pkg::rx_state_t state_q;   // current receive state
    wiper_pkg::rx_state_t state_d;
    logic [2:0]           bit_q;     // bit index inside the byte
    logic [2:0]           bit_d;
    logic [1:0]           byte_q;    // byte index inside the transfer
    logic [1:0]           byte_d;
    logic [7:0]           shift_q;   // incoming byte, msb first
    logic [7:0]           shift_d;
    logic [7:0]           cmd_q;     // accepted command byte
    logic [7:0]           cmd_d;
    logic                 oe_q;      // acknowledge drive
    logic                 oe_d;
    logic                 accept;    // current byte is acknowledged
    logic [1:0]           targets;   // wipers the command selects

    assign targets = cmd_targets(cmd_q);

    // decide whether the byte just received is ours to acknowledge
    always_comb begin
        case (byte_q)
            wiper_pkg::BYTE_ADDR: accept = (shift_q == own_addr);
            wiper_pkg::BYTE_CMD:  accept = |cmd_targets(shift_q);
            wiper_pkg::BYTE_DATA: accept = |targets;
            default:              accept = 1'b0;  // extra bytes refused
        endcase
    end

    // next state of the receiver
    always_comb begin
        state_d = state_q;
        bit_d   = bit_q;
        byte_d  = byte_q;
        shift_d = shift_q;
        cmd_d   = cmd_q;
        oe_d    = oe_q;
        if (start_seen) begin
            // start or repeated start opens a new transfer
            state_d = wiper_pkg::ST_RX;
            bit_d   = 3'h0;
            byte_d  = wiper_pkg::BYTE_ADDR;
            cmd_d   = 8'h00;
            oe_d    = 1'b0;
        end else if (stop_seen) begin
            // stop ends everything and frees the line
            state_d = wiper_pkg::ST_IDLE;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                wiper_pkg::ST_IDLE: begin
                    oe_d = 1'b0;
                end
                wiper_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s};
                        bit_d   = bit_q + 3'h1;
                        if (bit_q == wiper_pkg::LAST_BIT) begin
                            state_d = wiper_pkg::ST_DONE;
                        end
                    end
                end
                wiper_pkg::ST_DONE: begin
                    if (scl_fall) begin
                        if (accept) begin
                            // pull sda low for the acknowledge bit
                            state_d = wiper_pkg::ST_ACK;
                            oe_d    = 1'b1;
                            if (byte_q == wiper_pkg::BYTE_CMD) begin
                                cmd_d = shift_q;
                            end
                        end else begin
                            state_d = wiper_pkg::ST_IGNORE;
                        end
                    end
                end
                wiper_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        // release after the acknowledge clock
                        state_d = wiper_pkg::ST_RX;
                        oe_d    = 1'b0;
                        bit_d   = 3'h0;
                        if (byte_q != wiper_pkg::BYTE_LAST) begin
                            byte_d = byte_q + 2'h1;
                        end
                    end
                end
                wiper_pkg::ST_IGNORE: begin
                    oe_d = 1'b0;
                end
                default: begin
                    state_d = wiper_pkg::ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    // receiver registers
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= wiper_pkg::ST_IDLE;
            bit_q   <= 3'h0;
            byte_q  <= wiper_pkg::BYTE_ADDR;
            shift_q <= 8'h00;
            cmd_q   <= 8'h00;
            oe_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_q   <= bit_d;
            byte_q  <= byte_d;
            shift_q <= shift_d;
            cmd_q   <= cmd_d;
            oe_q    <= oe_d;
        end
    end

    // ---------------------------------------------------------------
    // wiper registers
    // ---------------------------------------------------------------
    wiper_pkg::wiper_pair_t low_q;    // taps from the low terminal
    wiper_pkg::wiper_pair_t low_d;
    wiper_pkg::wiper_pair_t high_q;   // taps from the high terminal
    wiper_pkg::wiper_pair_t high_d;
    logic                   upd_q;    // one-cycle update strobe
    logic                   upd_d;
    logic                   data_done; // data byte acknowledged now

    assign data_done = (state_q == wiper_pkg::ST_DONE) && scl_fall &&
                       !start_seen && !stop_seen &&
                       (byte_q == wiper_pkg::BYTE_DATA) && accept;

    // load the received code into the selected wipers
    always_comb begin
        low_d = low_q;
        upd_d = 1'b0;
        if (data_done) begin
            if (targets[0]) begin
                low_d.first_wiper = shift_q;
            end
            if (targets[1]) begin
                low_d.second_wiper = shift_q;
            end
            upd_d = 1'b1;
        end
        // code is the tap count from the low end, 255 at the top
        high_d.first_wiper  = wiper_pkg::FULL_SCALE -
                              low_d.first_wiper;
        high_d.second_wiper = wiper_pkg::FULL_SCALE -
                              low_d.second_wiper;
    end

    // wiper registers, midscale after reset
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_q  <= {wiper_pkg::MIDSCALE_CODE, wiper_pkg::MIDSCALE_CODE};
            high_q <= {wiper_pkg::FULL_SCALE - wiper_pkg::MIDSCALE_CODE,
                       wiper_pkg::FULL_SCALE - wiper_pkg::MIDSCALE_CODE};
            upd_q  <= 1'b0;
        end else begin
            low_q  <= low_d;
            high_q <= high_d;
            upd_q  <= upd_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs; sda only ever pulled low for acknowledge
    // ---------------------------------------------------------------
    assign sda_o                = 1'b0;
    assign sda_oe_o             = oe_q;
    assign taps_from_low_end_o  = low_q;
    assign taps_from_high_end_o = high_q;
    assign wiper_updated_o      = upd_q;

endmodule

// ===== hw/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to sys_clk_i
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] pin_i,
    input  wire logic [WIDTH-1:0] init_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta_q;   // first stage, read only by stage two
    logic [WIDTH-1:0] mid_q;    // second stage
    logic [WIDTH-1:0] late_q;   // third stage
    logic [WIDTH-1:0] level_q;  // accepted level
    logic [WIDTH-1:0] level_d;
    logic [1:0]       fill_q;   // edges since reset release, stops at 3
    logic [1:0]       fill_d;

    // a bit changes only once stages two and three agree;
    // until both hold real pin values the seed level stands
    always_comb begin
        level_d = level_q;
        fill_d  = fill_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (mid_q[i] == late_q[i]) begin
                level_d[i] = late_q[i];
            end
        end
        if (fill_q != 2'h3) begin
            fill_d  = fill_q + 2'h1;
            level_d = init_i;
        end
    end

    // register stages, constants only under reset
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q   <= '0;
            mid_q    <= '0;
            late_q   <= '0;
            level_q  <= '0;
            fill_q   <= 2'h0;
        end else begin
            meta_q   <= pin_i;
            mid_q    <= meta_q;
            late_q   <= mid_q;
            level_q  <= level_d;
            fill_q   <= fill_d;
        end
    end

    // seed shown under reset too, so no false edge follows release
    assign level_o = (fill_q == 2'h0) ? init_i : level_q;
endmodule

// ===== hw/wiper_pkg.sv
// constants, types and field layouts of the dual wiper write port
// assumes a single 125 MHz system clock domain
package wiper_pkg;

    // wiper geometry: one tap per code, counted from the low terminal
    localparam int          TAP_COUNT     = 256;
    localparam int          CODE_W        = 8;
    localparam logic [7:0]  MIDSCALE_CODE = 8'h80;  // reset tap
    localparam logic [7:0]  FULL_SCALE    = 8'hff;  // top tap

    // command byte values: wiper a, wiper b and both wipers
    localparam logic [7:0] WIPER_A_WRITE_CMD    = 8'h11;
    localparam logic [7:0] WIPER_B_WRITE_CMD    = 8'h12;
    localparam logic [7:0] DUAL_WIPER_WRITE_CMD = 8'h13;

    // target address in its 8-bit form, write bit included
    localparam logic [7:0] FIXED_TARGET_ADDR = 8'h5a;
    localparam logic [3:0] ADDR_UPPER_BITS   = 4'h5;  // 0101
    localparam logic       WRITE_BIT         = 1'b0;

    // byte positions inside one write transfer
    localparam logic [1:0] BYTE_ADDR = 2'h0;
    localparam logic [1:0] BYTE_CMD  = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;
    localparam logic [1:0] BYTE_LAST = 2'h3;  // any byte past the data

    // last bit index of a byte, msb first
    localparam logic [2:0] LAST_BIT = 3'h7;

    // pin synchroniser width (scl, sda, three address pins)
    localparam int SYNC_W = 5;

    // tap codes of both wipers travel together
    typedef struct packed {
        logic [7:0] first_wiper;   // wiper a code
        logic [7:0] second_wiper;  // wiper b code
    } wiper_pair_t;

    // target receive states
    typedef enum logic [2:0] {
        ST_IDLE,      // waiting for a start condition
        ST_RX,        // shifting in a byte on scl rising edges
        ST_DONE,      // eighth bit taken, waiting for scl to fall
        ST_ACK,       // driving the acknowledge bit low
        ST_IGNORE     // transfer not for us, wait for start or stop
    } rx_state_t;

endpackage

// ===== testbench/dual_wiper_properties.sv
// concurrent checks on the wiper port pins
// assumes one clock domain; bound into every port instance
`timescale 1ns/1ps
module dual_wiper_checker (
    input wire logic               sys_clk_i,
    input wire logic               resetn_i,
    input wire logic               scl_i,
    input wire logic               sda_o,
    input wire logic               sda_oe_o,
    input wiper_pkg::wiper_pair_t  taps_from_low_end_o,
    input wiper_pkg::wiper_pair_t  taps_from_high_end_o,
    input wire logic               wiper_updated_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // acknowledge starts, then stands for at least four cycles
    sequence s_ack_rise;
        $rose(sda_oe_o);
    endsequence
    sequence s_ack_hold;
        sda_oe_o [*4];
    endsequence
    AST_ACK_HELD: assert property (s_ack_rise |-> s_ack_hold)
        else $error("acknowledge dropped early");
    AST_ACK_ENDS: assert property (sda_oe_o |-> ##[1:1000] !sda_oe_o)
        else $error("acknowledge never released");
    AST_NO_DATA: assert property (sda_o == 1'b0)
        else $error("data value driven on sda");
    AST_ACK_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
        else $error("acknowledge began with scl high");
    AST_ACK_RELEASE: assert property ($fell(sda_oe_o) |-> !scl_i)
        else $error("acknowledge released with scl high");
    AST_HIGH_CODE: assert property (taps_from_high_end_o ==
        {8'hff - taps_from_low_end_o.first_wiper,
         8'hff - taps_from_low_end_o.second_wiper})
        else $error("high end code not complement");
    AST_TAPS_HELD: assert property (
        !wiper_updated_o |-> $stable(taps_from_low_end_o))
        else $error("wiper moved without update");
    AST_PULSE_ONE: assert property (wiper_updated_o |=> !wiper_updated_o)
        else $error("update pulse longer than one cycle");
    AST_UPDATE_ACK: assert property (wiper_updated_o |-> $rose(sda_oe_o))
        else $error("update not with data acknowledge");
    AST_ONE_OR_BOTH: assert property (wiper_updated_o |->
        $stable(taps_from_low_end_o.first_wiper) ||
        $stable(taps_from_low_end_o.second_wiper) ||
        taps_from_low_end_o.first_wiper == taps_from_low_end_o.second_wiper)
        else $error("both wipers moved to different codes");
    AST_RESET_MID: assert property ($rose(resetn_i) |->
        taps_from_low_end_o == {2{wiper_pkg::MIDSCALE_CODE}})
        else $error("wipers not at midscale after reset");
endmodule
bind dual_wiper_i2c_write_port dual_wiper_checker dual_wiper_checker_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .scl_i(scl_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .taps_from_low_end_o(taps_from_low_end_o),
    .taps_from_high_end_o(taps_from_high_end_o),
    .wiper_updated_o(wiper_updated_o));

// ===== testbench/i2c_ctrl_model.sv
// bus controller model that only ever issues write transfers
// assumes sda_i is the resolved wire with its pull-up
`timescale 1ns/1ps
module i2c_ctrl_model #(
    parameter int HALF_CYC = 156  // 400 khz phase at 125 mhz
) (
    input  wire logic sys_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // idle bus: both lines released
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    // step n clocks, then move just off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // one bit: data set in low phase, sampled back at end of high
    task automatic bit_out(input logic b, output logic seen);
        wt(2);
        sda_low_o = ~b;  // released for a one or an ack slot
        wt(HALF_CYC);
        scl_o = 1'b1;
        wt(HALF_CYC);
        seen = sda_i;
        scl_o = 1'b0;
    endtask
    // start, address, command, data, stop; no read ever issued
    task automatic write3(input logic [7:0] a, input logic [7:0] c,
                          input logic [7:0] d, output logic [2:0] nack);
        logic       s;
        logic [7:0] v;
        sda_low_o = 1'b1;  // start: sda falls while scl high
        wt(HALF_CYC);
        scl_o = 1'b0;
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? a : ((k == 1) ? c : d);
            for (int i = 7; i >= 0; i--) bit_out(v[i], s);
            bit_out(1'b1, s);
            nack[2-k] = s;
        end
        wt(2);
        sda_low_o = 1'b1;  // stop: sda rises while scl high
        wt(HALF_CYC);
        scl_o = 1'b1;
        wt(HALF_CYC);
        sda_low_o = 1'b0;
        wt(HALF_CYC);
    endtask
endmodule

// ===== testbench/test_dual_wiper_i2c_write_port.sv
// self-checking bench for the dual wiper write port
// assumes the controller model and the bound checker are compiled
`timescale 1ns/1ps
module test_dual_wiper_i2c_write_port;
    logic                   clk = 1'b0;
    logic                   resetn;
    logic                   scl;
    logic                   sda_low;
    logic                   sda_o;
    logic                   sda_oe;
    logic                   sda;
    logic                   upd;
    logic [2:0]             pins;      // address straps
    wiper_pkg::wiper_pair_t low;
    wiper_pkg::wiper_pair_t high;
    logic                   fixed_sda_o;  // fixed variant data value
    logic                   fixed_oe;     // fixed variant acknowledge
    logic                   fixed_upd;    // fixed variant update pulse
    wiper_pkg::wiper_pair_t fixed_low;
    wiper_pkg::wiper_pair_t fixed_high;
    int                     errors = 0;
    int                     total_checks = 0;
    int                     cycles = 0;
    int                     pulses = 0;  // seen update pulses
    int                     exp_p = 0;
    int                     fixed_pulses = 0;
    int                     exp_fp = 0;
    logic [7:0]             exp_a = wiper_pkg::MIDSCALE_CODE;
    logic [7:0]             exp_b = wiper_pkg::MIDSCALE_CODE;
    logic [7:0]             exp_fa = wiper_pkg::MIDSCALE_CODE;
    logic [7:0]             exp_fb = wiper_pkg::MIDSCALE_CODE;
    always #4 clk = ~clk;
    // open-drain wire with pull-up, both ports on it
    assign sda = ~(sda_low | (sda_oe & ~sda_o) |
                   (fixed_oe & ~fixed_sda_o));
    dual_wiper_i2c_write_port dual_wiper_i2c_write_port_inst (
        .sys_clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_bit2_i(pins[2]),
        .addr_select_bit1_i(pins[1]), .addr_select_bit0_i(pins[0]),
        .taps_from_low_end_o(low), .taps_from_high_end_o(high),
        .wiper_updated_o(upd));
    // fixed address variant on the same bus
    dual_wiper_i2c_write_port #(
        .FIXED_ADDR_VARIANT(1'b1)
    ) dual_wiper_i2c_write_port_fixed_inst (
        .sys_clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda),
        .sda_o(fixed_sda_o), .sda_oe_o(fixed_oe),
        .addr_select_bit2_i(pins[2]), .addr_select_bit1_i(pins[1]),
        .addr_select_bit0_i(pins[0]), .taps_from_low_end_o(fixed_low),
        .taps_from_high_end_o(fixed_high), .wiper_updated_o(fixed_upd));
    // short phases keep the run brief
    i2c_ctrl_model #(.HALF_CYC(16)) i2c_ctrl_model_inst (
        .sys_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    // count update pulses and cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (upd === 1'b1) pulses++;
        if (fixed_upd === 1'b1) fixed_pulses++;
        if (cycles == 60000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // own address: fixed upper bits, straps, write bit
    function automatic logic [7:0] own();
        return {wiper_pkg::ADDR_UPPER_BITS, pins, wiper_pkg::WRITE_BIT};
    endfunction
    // one transfer, then model update and compare
    task automatic xfer(input logic [7:0] a, input logic [7:0] c,
                        input logic [7:0] d);
        logic [2:0] nk;
        logic       ok;      // strap-addressed port takes the write
        logic       ok_f;    // fixed-address port takes the write
        logic       hit;     // some port owns the address
        logic       nak;     // command and data refused by both
        logic       cmd_ok;
        cmd_ok = c inside {wiper_pkg::WIPER_A_WRITE_CMD,
             wiper_pkg::WIPER_B_WRITE_CMD, wiper_pkg::DUAL_WIPER_WRITE_CMD};
        hit  = (a === own()) || (a === wiper_pkg::FIXED_TARGET_ADDR);
        ok   = (a === own()) && cmd_ok;
        ok_f = (a === wiper_pkg::FIXED_TARGET_ADDR) && cmd_ok;
        nak  = ~(ok | ok_f);
        i2c_ctrl_model_inst.write3(a, c, d, nk);
        if (ok && c != wiper_pkg::WIPER_B_WRITE_CMD) exp_a = d;
        if (ok && c != wiper_pkg::WIPER_A_WRITE_CMD) exp_b = d;
        if (ok_f && c != wiper_pkg::WIPER_B_WRITE_CMD) exp_fa = d;
        if (ok_f && c != wiper_pkg::WIPER_A_WRITE_CMD) exp_fb = d;
        if (ok) exp_p++;
        if (ok_f) exp_fp++;
        chk("ack bits", {13'h0, ~hit, nak, nak}, {13'h0, nk});
        chk("low taps", {exp_a, exp_b}, low);
        chk("high taps", {8'hff - exp_a, 8'hff - exp_b}, high);
        chk("pulses", 16'(exp_p), 16'(pulses));
        chk("fixed taps", {exp_fa, exp_fb}, fixed_low);
        chk("fixed high", {8'hff - exp_fa, 8'hff - exp_fb}, fixed_high);
        chk("fixed pulses", 16'(exp_fp), 16'(fixed_pulses));
    endtask
    initial begin
        void'($urandom(32'h0dc00c0f));
        resetn = 1'b0;
        pins   = 3'h5;
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (12) @(posedge clk);
        chk("reset taps", {exp_a, exp_b}, low);
        chk("fixed reset taps", {exp_fa, exp_fb}, fixed_low);
        // every command with both end codes and a random code
        for (int k = 0; k < 3; k++) begin
            xfer(own(), 8'h11 + 8'(k), 8'h00);
            xfer(own(), 8'h11 + 8'(k), 8'hff);
            xfer(own(), 8'h11 + 8'(k), 8'($urandom));
        end
        // refused: foreign address, read bit, unknown commands
        xfer(own() ^ 8'h02, 8'h11, 8'h3c);
        xfer(own() | 8'h01, 8'h12, 8'h5e);
        xfer(own(), 8'h10, 8'h21);
        xfer(own(), 8'h14, 8'h43);
        // new strap setting, then a random mix
        pins = 3'($urandom_range(0, 4));  // straps never give 0x5a
        repeat (12) @(posedge clk);
        #1;
        xfer(wiper_pkg::FIXED_TARGET_ADDR, wiper_pkg::WIPER_B_WRITE_CMD,
             8'($urandom));
        for (int k = 0; k < 8; k++)
            xfer(($urandom_range(0, 3) == 0) ? own() ^ 8'h08 : own(),
                 8'h10 + 8'($urandom_range(0, 4)), 8'($urandom));
        xfer(own(), wiper_pkg::DUAL_WIPER_WRITE_CMD,
             wiper_pkg::MIDSCALE_CODE);
        xfer(wiper_pkg::FIXED_TARGET_ADDR, wiper_pkg::DUAL_WIPER_WRITE_CMD,
             wiper_pkg::MIDSCALE_CODE);
        tally_and_finish();
    end
endmodule
